// ---- hdl/ioam_pkg.sv ----
package ioam_pkg;

   localparam int IN_FUNC_N = 9;
   localparam int IN_CIRC_N = 7;
   localparam int OUT_FUNC_N = 10;
   localparam int OUT_CIRC_N = 3;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] INPUT_MAP_PARAM_A_OFS = 12'h000;
   localparam logic [11:0] INPUT_MAP_PARAM_B_OFS = 12'h004;
   localparam logic [11:0] INPUT_MAP_PARAM_C_OFS = 12'h008;
   localparam logic [11:0] INPUT_MAP_PARAM_D_OFS = 12'h00c;
   localparam logic [11:0] OUTPUT_MAP_PARAM_A_OFS = 12'h010;
   localparam logic [11:0] OUTPUT_MAP_PARAM_B_OFS = 12'h014;
   localparam logic [11:0] OUTPUT_MAP_PARAM_C_OFS = 12'h018;
   localparam logic [11:0] OUTPUT_MAP_PARAM_D_OFS = 12'h01c;
   localparam logic [11:0] OUTPUT_POLARITY_PARAM_OFS = 12'h020;
   localparam logic [11:0] INPUT_STATUS_OFS = 12'h024;
   localparam logic [11:0] OUTPUT_STATUS_OFS = 12'h028;

   // Reset values of the allocation words.
   localparam logic [15:0] INPUT_MAP_PARAM_A_RST = 16'h1000;
   localparam logic [15:0] INPUT_MAP_PARAM_B_RST = 16'h8802;
   localparam logic [15:0] INPUT_MAP_PARAM_C_RST = 16'h8888;
   localparam logic [15:0] INPUT_MAP_PARAM_D_RST = 16'h0008;
   localparam logic [15:0] OUTPUT_MAP_PARAM_RST = 16'h0000;
   localparam logic [2:0] OUTPUT_POLARITY_RST = 3'h0;

   // Input and output selector codes.
   localparam logic [3:0] IN_CODE_LAST_DIRECT = 4'h6;
   localparam logic [3:0] IN_CODE_FORCE_ON = 4'h7;
   localparam logic [3:0] IN_CODE_FORCE_OFF = 4'h8;
   localparam logic [3:0] IN_CODE_FIRST_INV = 4'h9;
   localparam logic [3:0] OUT_CODE_MAX = 4'h3;

   // Input functions, index 0 to 8: forward_travel_inhibit, reverse_travel_inhibit,
   // forward_ext_torque_limit, reverse_ext_torque_limit, homing_decel_switch,
   // ext_latch_in_1, ext_latch_in_2, ext_latch_in_3, forced_halt_in.
   // Nibble position 0 to 15 across the four input words, word A lowest.
   localparam logic [8:0][3:0] IN_NIB_POS =
      '{4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h4, 4'h3};
   localparam logic [8:0] IN_LOW_NAMED = 9'h0fc;
   localparam logic [8:0] IN_EDGE_EVAL = 9'h0e0;

   // Output functions, index 0 to 9: position_reached_out, speed_match_out,
   // motion_detect_out, drive_ready_out, torque_limit_hit_out, speed_limit_hit_out,
   // holding_brake_out, warning_out, near_target_out, maintenance_due_out.
   localparam logic [9:0][3:0] OUT_NIB_POS =
      '{4'hd, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
   localparam logic [9:0] OUT_NEED_POS = 10'h001;
   localparam logic [9:0] OUT_NEED_SPD = 10'h002;

   // Status field positions.
   localparam int IN_STAT_FUNC_LSB = 16;
   localparam int OUT_STAT_CONTACT_LSB = 16;

   typedef enum logic [2:0]
   {
      MODE_POSITION = 3'b001,
      MODE_SPEED = 3'b010,
      MODE_TORQUE = 3'b100
   } ioam_mode_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ioam_apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ioam_apb_rsp_t;

   typedef struct packed
   {
      logic [3:0][15:0] in_map;
      logic [3:0][15:0] out_map;
      logic [2:0] out_pol;
      logic [8:0] in_func;
      logic [2:0] contact_out;
      ioam_apb_rsp_t rsp;
   } ioam_state_t;

   localparam ioam_state_t ST_RST = '{
      in_map: {INPUT_MAP_PARAM_D_RST, INPUT_MAP_PARAM_C_RST,
               INPUT_MAP_PARAM_B_RST, INPUT_MAP_PARAM_A_RST},
      out_map: {4{OUTPUT_MAP_PARAM_RST}},
      out_pol: OUTPUT_POLARITY_RST,
      in_func: 9'h000,
      contact_out: 3'h0,
      rsp: '0};

endpackage

// ---- hdl/ioam_in_sel.sv ----
`timescale 1ns/10ps
module ioam_in_sel import ioam_pkg::*;
(
   // Selector and contacts.
   input wire logic [3:0] code,
   input wire logic [IN_CIRC_N-1:0] contacts,
   // Function character.
   input wire logic low_named,
   input wire logic edge_eval,
   // Result.
   output logic asserted
);

   always_comb
   begin
      asserted = 1'b0;
      if (code <= IN_CODE_LAST_DIRECT)
      begin
         // A closed contact asserts a low-named function, an open one a high-named one.
         asserted = contacts[code[2:0]] ~^ low_named;
      end
      else if (code == IN_CODE_FORCE_ON)
      begin
         // An edge-evaluated function would never see an edge, so it stays quiet.
         asserted = ~edge_eval;
      end
      else if (code == IN_CODE_FORCE_OFF)
      begin
         asserted = 1'b0;
      end
      else
      begin
         asserted = ~(contacts[3'(code - IN_CODE_FIRST_INV)] ~^ low_named);
      end
   end

endmodule

// ---- hdl/ioam_matrix.sv ----
`timescale 1ns/10ps
module ioam_matrix import ioam_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire ioam_apb_req_t apb_req,
   output ioam_apb_rsp_t apb_rsp,
   // Control side.
   input wire ioam_mode_t ctrl_mode,
   input wire logic [OUT_FUNC_N-1:0] out_func_raw,
   output logic [IN_FUNC_N-1:0] in_func,
   // Connector side, 1 means contact closed.
   input wire logic [IN_CIRC_N-1:0] contact_in,
   output logic [OUT_CIRC_N-1:0] contact_out
);

   ioam_state_t st;
   ioam_state_t next_st;
   logic [63:0] in_all;
   logic [63:0] out_all;
   logic [IN_FUNC_N-1:0][3:0] in_code;
   logic [IN_FUNC_N-1:0] in_dec;
   logic [IN_FUNC_N-1:0] ref_c;
   logic [OUT_FUNC_N-1:0][1:0] out_code;
   logic [OUT_FUNC_N-1:0] out_live;
   logic [OUT_CIRC_N-1:0] out_or;
   logic setup;
   logic access;
   logic hit;
   logic [31:0] rdata;
   logic [3:0] wr_in;
   logic [3:0] wr_out;
   logic wr_pol;

   assign in_all = st.in_map;
   assign out_all = st.out_map;
   assign apb_rsp = st.rsp;
   assign in_func = st.in_func;
   assign contact_out = st.contact_out;

   for (genvar f = 0; f < IN_FUNC_N; f++)
   begin : g_in
      assign in_code[f] = in_all[{IN_NIB_POS[f], 2'h0} +: 4];
      // Every function that picks a circuit with the same code reads that one contact, so all of them with
      // the same IN_LOW_NAMED move together, and the others move opposite.
      ioam_in_sel u_sel
      (
         .code(in_code[f]),
         .contacts(contact_in),
         .low_named(IN_LOW_NAMED[f]),
         .edge_eval(IN_EDGE_EVAL[f]),
         .asserted(in_dec[f])
      );
      assign ref_c[f] = (in_code[f] <= IN_CODE_LAST_DIRECT) ? contact_in[in_code[f][2:0]]
                        : contact_in[3'(in_code[f] - IN_CODE_FIRST_INV)];
   end

   for (genvar f = 0; f < OUT_FUNC_N; f++)
   begin : g_out
      logic [3:0] raw_code;
      assign raw_code = out_all[{OUT_NIB_POS[f], 2'h0} +: 4];
      // Codes above 3 have no circuit and are taken as disabled.
      assign out_code[f] = (raw_code > OUT_CODE_MAX) ? 2'h0 : raw_code[1:0];
      assign out_live[f] = out_func_raw[f]
         & ~(OUT_NEED_POS[f] & (ctrl_mode != MODE_POSITION))
         & ~(OUT_NEED_SPD[f] & (ctrl_mode != MODE_SPEED));
   end

   for (genvar k = 0; k < OUT_CIRC_N; k++)
   begin : g_circ
      logic [OUT_FUNC_N-1:0] pick;
      for (genvar f = 0; f < OUT_FUNC_N; f++)
      begin : g_pick
         assign pick[f] = (out_code[f] == 2'(k + 1));
      end
      assign out_or[k] = |(pick & out_live);
   end

   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable & st.rsp.pready;

   always_comb
   begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      wr_in = 4'h0;
      wr_out = 4'h0;
      wr_pol = 1'b0;
      if (apb_req.paddr == INPUT_MAP_PARAM_A_OFS)
      begin
         rdata = {16'h0000, st.in_map[0]};
         wr_in[0] = 1'b1;
      end
      else if (apb_req.paddr == INPUT_MAP_PARAM_B_OFS)
      begin
         rdata = {16'h0000, st.in_map[1]};
         wr_in[1] = 1'b1;
      end
      else if (apb_req.paddr == INPUT_MAP_PARAM_C_OFS)
      begin
         rdata = {16'h0000, st.in_map[2]};
         wr_in[2] = 1'b1;
      end
      else if (apb_req.paddr == INPUT_MAP_PARAM_D_OFS)
      begin
         rdata = {16'h0000, st.in_map[3]};
         wr_in[3] = 1'b1;
      end
      else if (apb_req.paddr == OUTPUT_MAP_PARAM_A_OFS)
      begin
         rdata = {16'h0000, st.out_map[0]};
         wr_out[0] = 1'b1;
      end
      else if (apb_req.paddr == OUTPUT_MAP_PARAM_B_OFS)
      begin
         rdata = {16'h0000, st.out_map[1]};
         wr_out[1] = 1'b1;
      end
      else if (apb_req.paddr == OUTPUT_MAP_PARAM_C_OFS)
      begin
         rdata = {16'h0000, st.out_map[2]};
         wr_out[2] = 1'b1;
      end
      else if (apb_req.paddr == OUTPUT_MAP_PARAM_D_OFS)
      begin
         rdata = {16'h0000, st.out_map[3]};
         wr_out[3] = 1'b1;
      end
      else if (apb_req.paddr == OUTPUT_POLARITY_PARAM_OFS)
      begin
         rdata = {29'h0000_0000, st.out_pol};
         wr_pol = 1'b1;
      end
      else if (apb_req.paddr == INPUT_STATUS_OFS)
      begin
         rdata = {7'h00, st.in_func, 9'h000, contact_in};
      end
      else if (apb_req.paddr == OUTPUT_STATUS_OFS)
      begin
         rdata = {13'h0000, st.contact_out, 6'h00, out_live};
      end
      else
      begin
         hit = 1'b0;
      end
   end

   always_comb
   begin
      next_st = st;
      next_st.in_func = in_dec;
      // Inversion flips both states, so an idle inverted circuit sits closed.
      next_st.contact_out = out_or ^ st.out_pol;
      // Ready is raised for the access cycle only, giving every transfer one wait-free
      // access while keeping every bus output registered.
      next_st.rsp.pready = setup;
      if (setup)
      begin
         next_st.rsp.prdata = rdata;
         next_st.rsp.pslverr = ~hit;
      end
      if (access && apb_req.pwrite)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wr_in[i])
            begin
               next_st.in_map[i] = apb_req.pwdata[15:0];
            end
            if (wr_out[i])
            begin
               next_st.out_map[i] = apb_req.pwdata[15:0];
            end
         end
         if (wr_pol)
         begin
            next_st.out_pol = apb_req.pwdata[2:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence pol_write_s;
      access && apb_req.pwrite && (apb_req.paddr == OUTPUT_POLARITY_PARAM_OFS);
   endsequence

   sequence stat_read_s;
      setup && (apb_req.paddr == OUTPUT_STATUS_OFS) && (ctrl_mode != MODE_POSITION);
   endsequence

   for (genvar f = 0; f < IN_FUNC_N; f++)
   begin : g_in_chk
      // The first edge after release still shows the reset outputs, so no attempt
      // starts while reset is sampled low.
      direct_map_a: assert property (
         presetn && (in_code[f] <= IN_CODE_LAST_DIRECT)
         |=> in_func[f] == ($past(ref_c[f]) ~^ IN_LOW_NAMED[f]))
         else $error("direct input selection gives wrong level");
      invert_map_a: assert property (
         presetn && (in_code[f] >= IN_CODE_FIRST_INV)
         |=> in_func[f] == !($past(ref_c[f]) ~^ IN_LOW_NAMED[f]))
         else $error("inverted input selection gives wrong level");
      force_on_a: assert property (
         (in_code[f] == IN_CODE_FORCE_ON) [*2] |-> in_func[f] == !IN_EDGE_EVAL[f])
         else $error("forced-active input has wrong level");
      force_off_a: assert property (
         (in_code[f] == IN_CODE_FORCE_OFF) |=> !in_func[f])
         else $error("forced-inactive input is asserted");
      if (f > 0 && IN_LOW_NAMED[f] == IN_LOW_NAMED[0])
      begin : g_share
         shared_in_a: assert property (
            (in_code[f] == in_code[0]) && (in_code[0] != IN_CODE_FORCE_ON)
            |=> in_func[f] == in_func[0])
            else $error("functions on one input circuit disagree");
      end
   end

   for (genvar k = 0; k < OUT_CIRC_N; k++)
   begin : g_out_chk
      for (genvar f = 0; f < OUT_FUNC_N; f++)
      begin : g_f
         out_or_a: assert property (
            out_func_raw[f] && !OUT_NEED_POS[f] && !OUT_NEED_SPD[f]
            && (out_code[f] == 2'(k + 1))
            |=> contact_out[k] != $past(st.out_pol[k]))
            else $error("mapped output function does not reach its circuit");
      end
      close_level_a: assert property (
         !out_or[k] |=> contact_out[k] == $past(st.out_pol[k]))
         else $error("idle output circuit has wrong contact state");
   end

   all_off_a: assert property (
      (out_code == '0) |=> contact_out == $past(st.out_pol))
      else $error("disabled outputs still drive a circuit");

   mode_gate_a: assert property (
      stat_read_s |=> !apb_rsp.prdata[0] && apb_rsp.pready)
      else $error("unevaluated output function is shown active");

   pol_write_a: assert property (
      pol_write_s |=> st.out_pol == $past(apb_req.pwdata[2:0]))
      else $error("polarity write not taken");

endmodule

// ---- verification/ioam_contact_model.sv ----
`timescale 1ns/10ps
module ioam_contact_model
(
   // Switches set by the bench, 1 means closed.
   input wire logic [6:0] switch_closed,
   input wire logic [2:0] contact_out,
   // Contacts seen by the block and relay loads.
   output logic [6:0] contact_in,
   output logic [2:0] load_on
);
   // Dry contacts have no released state, so a switch is always open or closed.
   assign contact_in = switch_closed;
   // A relay load is energised only while its output contact is closed.
   assign load_on = contact_out;
endmodule

// ---- verification/test_io_signal_allocation_matrix.sv ----
`timescale 1ns/10ps
module test_io_signal_allocation_matrix import ioam_pkg::*; ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   ioam_apb_req_t req = '0;
   ioam_apb_rsp_t rsp;
   ioam_mode_t mode = MODE_POSITION;
   logic [9:0] ofr = '0;
   logic [6:0] want = '0;
   logic [6:0] cin;
   logic [8:0] infn;
   logic [2:0] cout;
   logic [2:0] load;
   logic [31:0] rnd = 32'h3b;
   logic [15:0] m [0:8];
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;

   always #5 pclk = ~pclk;

   ioam_matrix i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .ctrl_mode(mode), .out_func_raw(ofr), .in_func(infn), .contact_in(cin),
      .contact_out(cout));
   ioam_contact_model i_sw (.switch_closed(want), .contact_out(cout), .contact_in(cin),
      .load_on(load));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [8:0] exp_in(input logic [6:0] c);
      logic [3:0] k;
      logic [8:0] f;
      for (int i = 0; i < 9; i++)
      begin
         k = m[IN_NIB_POS[i][3:2]][IN_NIB_POS[i][1:0] * 4 +: 4];
         if (k == 4'h7)
            f[i] = !IN_EDGE_EVAL[i];
         else if (k == 4'h8)
            f[i] = 1'b0;
         else
            f[i] = c[k <= 4'h6 ? k : k - 4'h9] ^ !IN_LOW_NAMED[i] ^ (k >= 4'h9);
      end
      return f;
   endfunction

   function automatic logic [9:0] exp_live();
      logic [9:0] g;
      g = ofr;
      g[0] = ofr[0] && mode == MODE_POSITION;
      g[1] = ofr[1] && mode == MODE_SPEED;
      return g;
   endfunction

   function automatic logic [2:0] exp_out();
      logic [3:0] k;
      logic [2:0] o;
      logic [9:0] g;
      o = 3'h0;
      g = exp_live();
      for (int i = 0; i < 10; i++)
      begin
         k = m[4 + OUT_NIB_POS[i][3:2]][OUT_NIB_POS[i][1:0] * 4 +: 4];
         if (k >= 4'h1 && k <= 4'h3)
            o[k - 4'h1] = o[k - 4'h1] | g[i];
      end
      return o ^ m[8][2:0];
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The reply is taken at the edge where ready is seen, before that edge replaces it.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output ioam_apb_rsp_t r);
      int w;
      w = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         w++;
      end
      while (rsp.pready !== 1'b1 && w < 50);
      r = rsp;
      check("bus answer", {31'h0, r.pready}, 32'h1);
      req <= '0;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      ioam_apb_rsp_t r;
      logic [3:0] nib;
      m = '{16'h1000, 16'h8802, 16'h8888, 16'h0008, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 9; k++)
      begin
         apb(1'b0, 12'(k * 4), 32'h0, r);
         check("reset word", r.prdata, {16'h0, m[k]});
         check("read error", {31'h0, r.pslverr}, 32'h0);
      end
      apb(1'b0, 12'h0fc, 32'h0, r);
      check("unmapped error", {31'h0, r.pslverr}, 32'h1);
      check("unmapped data", r.prdata, 32'h0);
      check("reset in_func", 32'(infn), 32'(exp_in(want)));
      $display("test reset done");
      for (int i = 0; i < 48; i++)
      begin
         for (int k = 0; k < 9; k++)
         begin
            rnd = xs(rnd);
            m[k] = (k >= 4 && k < 8 && i[0]) ? rnd[15:0] & 16'h3333 : rnd[15:0];
         end
         m[0][15:12] = 4'(i);
         // Latch inputs stay off circuits 4 to 6 in either polarity.
         for (int j = 1; j < 4; j++)
         begin
            nib = m[2][j * 4 +: 4];
            if (nib inside {4'h4, 4'h5, 4'h6, 4'hd, 4'he, 4'hf})
               m[2][j * 4 +: 4] = nib - 4'h4;
         end
         for (int k = 0; k < 9; k++)
            apb(1'b1, 12'(k * 4), {16'h0, m[k]}, r);
         rnd = xs(rnd);
         @(posedge pclk);
         want <= rnd[6:0];
         ofr <= rnd[16:7];
         mode <= i % 3 == 0 ? MODE_POSITION : i % 3 == 1 ? MODE_SPEED : MODE_TORQUE;
         repeat (2) @(posedge pclk);
         #1;
         check("in_func", 32'(infn), 32'(exp_in(want)));
         check("contact_out", 32'(load), 32'(exp_out()));
         apb(1'b1, INPUT_STATUS_OFS, 32'hffff_ffff, r);
         apb(1'b0, INPUT_STATUS_OFS, 32'h0, r);
         check("input status", r.prdata, {7'h0, exp_in(want), 9'h0, want});
         apb(1'b0, OUTPUT_STATUS_OFS, 32'h0, r);
         check("output status", r.prdata, {13'h0, exp_out(), 6'h0, exp_live()});
         apb(1'b0, OUTPUT_POLARITY_PARAM_OFS, 32'h0, r);
         check("polarity word", r.prdata, {29'h0, m[8][2:0]});
      end
      $display("test random allocation done");
      final_report();
   end
endmodule
